// ==== hw/dsrp_pkg.sv ====
package dsrp_pkg;

  // ------------------------------------------------------------------
  // widths and fixed values
  // ------------------------------------------------------------------
  localparam int         DATA_W         = 8;
  localparam int         NUM_SOURCES    = 16;
  localparam logic [7:0] SPI_CMD_WRITE  = 8'h90;
  localparam logic [7:0] SPI_CMD_READ   = 8'h91;
  localparam logic [7:0] SPI_PTR_MASK   = 8'h3f;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [3:0] I2C_ADDR_UPPER = 4'h9;
  localparam logic [2:0] I2C_ADDR_LOW   = 3'h0;
  localparam logic [2:0] I2C_ADDR_FLOAT = 3'h2;
  localparam logic [2:0] I2C_ADDR_HIGH  = 3'h3;
  localparam logic [1:0] ADD_PIN_LOW    = 2'h0;
  localparam logic [1:0] ADD_PIN_FLOAT  = 2'h1;
  localparam logic [1:0] ADD_PIN_HIGH   = 2'h2;
  localparam logic [1:0] LOCK_LAST_EDGE = 2'h2;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [7:0] STATUS1_ADDR   = 8'h00;
  localparam logic [7:0] STATUS2_ADDR   = 8'h01;

  // ------------------------------------------------------------------
  // carriers and states
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CMD   = 3'b001,
    S_PTR   = 3'b010,
    S_WDATA = 3'b011,
    S_READ  = 3'b100,
    S_SKIP  = 3'b101
  } spi_state_t;

  typedef enum logic [2:0] {
    I_IDLE  = 3'b000,
    I_RX    = 3'b001,
    I_ACK   = 3'b010,
    I_TX    = 3'b011,
    I_TXACK = 3'b100
  } i2c_state_t;

  // spi pointer step, wrapping inside the auto-increment window
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = (p + 8'h01) & SPI_PTR_MASK;
  endfunction : ptr_inc

endpackage : dsrp_pkg

// ==== hw/dual_serial_register_port.sv ====
`timescale 1ns/1ps
// How it works
// - i2c pointer-only write loads the pointer, writes no register
// - registers are 8 bits; i2c write is address, pointer, one data byte
// - extra i2c data bytes overwrite the same register, last byte stays
// - i2c read returns the pointed register, pointer does not move
// - spi uses chip select, clock, data in, data out; cs frames
// - spi side is slave only, host drives the serial clock
// - first spi byte is a command: 90h write, 91h read
// - spi data in is sampled on rising clock edges
// - spi data out floats while cs high; input counts after cs falls
// - spi write: byte after command sets pointer, then 00h..3Fh increment
// - spi read: command byte, then selected register on next eight clocks
// - spi data out changes on falling clock edges
// - continued spi read returns successive registers, wrapping 3Fh to 00h
// - alert active level follows polarity bit, active low after reset
// - alert disable bit high turns the alert output off
// - any out-of-limit conversion asserts the alert
// - alert clears only once back in limits and status was read
// - two status bytes record which source raised the alert
// - alert pin only pulls low or releases
// - i2c at start; third cs rising edge locks spi for good
// - i2c address is 1001 plus three bits from the select pin
module dual_serial_register_port
  import dsrp_pkg::*;
(
  input  wire logic                   MCLK,
  input  wire logic                   RESET,
  input  wire logic                   MCLK_EN,
  input  wire logic                   SCL,
  input  wire logic                   SDA_I,
  output logic                        SDA_O,
  output logic                        SDA_OE,
  input  wire logic                   CS_N,
  input  wire logic                   SCLK,
  input  wire logic                   DIN,
  output logic                        DOUT,
  output logic                        DOUT_OE,
  input  wire logic [1:0]             ADD_LEVEL,
  output logic [7:0]                  REG_ADDR,
  input  wire logic [7:0]             REG_RDATA,
  output reg_wr_t                     REG_WR,
  output logic                        REG_WE,
  output logic                        REG_RE,
  input  wire logic                   CONV_DONE,
  input  wire logic [NUM_SOURCES-1:0] LIMIT_FAULT,
  input  wire logic                   ALERT_POLARITY,
  input  wire logic                   ALERT_DISABLE,
  output logic                        ALERT_O,
  output logic                        ALERT_OE,
  output logic                        SPI_LOCKED
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  // order: scl, sda, cs_n, byte toggle, add level (2)
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [3:0] sync3;
  logic       link_rst;
  logic [7:0] spi_rx;
  logic       spi_tgl;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      sync1 <= 6'h3f;
      sync2 <= 6'h3f;
      sync3 <= 4'hf;
    end else if (MCLK_EN) begin
      sync1 <= {SCL, SDA_I, CS_N, spi_tgl, ADD_LEVEL};
      sync2 <= sync1;
      sync3 <= sync2[5:2];
    end
  end

  // registered copy of reset clears the link-side toggle asynchronously
  always_ff @(posedge MCLK) begin
    link_rst <= RESET;
  end

  wire scl_h    = sync2[5];
  wire sda_h    = sync2[4];
  wire cs_h     = sync2[3];
  wire scl_rise = sync2[5] & ~sync3[3];
  wire scl_fall = ~sync2[5] & sync3[3];
  wire sda_rise = sync2[4] & ~sync3[2];
  wire sda_fall = ~sync2[4] & sync3[2];
  wire cs_rise  = sync2[3] & ~sync3[1];
  wire cs_fall  = ~sync2[3] & sync3[1];
  wire spi_byte = sync2[2] ^ sync3[0];

  // ------------------------------------------------------------------
  // link-clock shifter
  // ------------------------------------------------------------------
  logic [7:0] rd_hold;

  spi_link_shifter u_link (
    .sclk     (SCLK),
    .cs_n     (CS_N),
    .link_rst (link_rst),
    .din      (DIN),
    .tx_word  (rd_hold),
    .rx_byte  (spi_rx),
    .byte_tgl (spi_tgl),
    .dout     (DOUT)
  );

  // ------------------------------------------------------------------
  // own address from the three-level select pin
  // ------------------------------------------------------------------
  function automatic logic [6:0] own_addr(input logic [1:0] lvl);
    unique case (lvl)
      ADD_PIN_HIGH:  own_addr = {I2C_ADDR_UPPER, I2C_ADDR_HIGH};
      ADD_PIN_FLOAT: own_addr = {I2C_ADDR_UPPER, I2C_ADDR_FLOAT};
      default:       own_addr = {I2C_ADDR_UPPER, I2C_ADDR_LOW};
    endcase
  endfunction : own_addr

  // ------------------------------------------------------------------
  // mode lock
  // ------------------------------------------------------------------
  logic [1:0] lock_cnt;
  logic [1:0] next_lock_cnt;
  logic       next_spi_locked;

  // no unlock path short of reset; the interface stays spi once chosen
  always_comb begin
    next_lock_cnt   = lock_cnt;
    next_spi_locked = SPI_LOCKED;
    if (!SPI_LOCKED && cs_rise) begin
      next_lock_cnt = lock_cnt + 2'h1;
      if (lock_cnt == LOCK_LAST_EDGE) begin
        next_spi_locked = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      lock_cnt   <= 2'h0;
      SPI_LOCKED <= 1'b0;
    end else if (MCLK_EN) begin
      lock_cnt   <= next_lock_cnt;
      SPI_LOCKED <= next_spi_locked;
    end
  end

  // ------------------------------------------------------------------
  // protocol engines and shared pointer
  // ------------------------------------------------------------------
  spi_state_t spi_state;
  spi_state_t next_spi_state;
  i2c_state_t i2c_state;
  i2c_state_t next_i2c_state;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic [3:0] i_bit;
  logic [3:0] next_i_bit;
  logic [7:0] i_shift;
  logic [7:0] next_i_shift;
  logic [1:0] i_idx;
  logic [1:0] next_i_idx;
  logic       i_rw;
  logic       next_i_rw;
  logic       next_sda_oe;
  logic       next_reg_we;
  logic       next_reg_re;
  reg_wr_t    next_reg_wr;
  logic [7:0] next_reg_addr;
  logic       next_dout_oe;

  always_comb begin
    next_spi_state = spi_state;
    next_i2c_state = i2c_state;
    next_ptr       = ptr;
    next_i_bit     = i_bit;
    next_i_shift   = i_shift;
    next_i_idx     = i_idx;
    next_i_rw      = i_rw;
    next_sda_oe    = SDA_OE;
    next_reg_we    = 1'b0;
    next_reg_re    = 1'b0;
    next_reg_wr    = REG_WR;
    if (SPI_LOCKED) begin
      // cs marks every frame; the first byte is always a command
      next_i2c_state = I_IDLE;
      next_sda_oe    = 1'b0;
      if (cs_rise) begin
        next_spi_state = S_IDLE;
      end else if (cs_fall) begin
        next_spi_state = S_CMD;
      end else if (spi_byte) begin
        unique case (spi_state)
          S_CMD: begin
            if (spi_rx == SPI_CMD_WRITE) begin
              next_spi_state = S_PTR;
            end else if (spi_rx == SPI_CMD_READ) begin
              next_spi_state = S_READ;
            end else begin
              next_spi_state = S_SKIP;
            end
          end
          S_PTR: begin
            next_ptr       = spi_rx;
            next_spi_state = S_WDATA;
          end
          S_WDATA: begin
            next_reg_we = 1'b1;
            next_reg_wr = '{addr: ptr, data: spi_rx};
            next_ptr    = ptr_inc(ptr);
          end
          S_READ: begin
            next_reg_re      = 1'b1;
            next_reg_wr.addr = ptr;
            next_ptr         = ptr_inc(ptr);
          end
          S_IDLE, S_SKIP: begin
            next_spi_state = spi_state;
          end
          default: next_spi_state = S_IDLE;
        endcase
      end
    end else if (scl_h && sda_fall) begin
      next_i2c_state = I_RX;
      next_i_bit     = 4'h0;
      next_i_idx     = 2'h0;
      next_sda_oe    = 1'b0;
    end else if (scl_h && sda_rise) begin
      next_i2c_state = I_IDLE;
      next_sda_oe    = 1'b0;
    end else begin
      unique case (i2c_state)
        I_IDLE: next_i2c_state = I_IDLE;
        I_RX: begin
          if (scl_rise) begin
            next_i_shift = {i_shift[6:0], sda_h};
            next_i_bit   = i_bit + 4'h1;
          end else if (scl_fall && i_bit == BITS_PER_BYTE) begin
            next_i2c_state = I_ACK;
            next_sda_oe    = 1'b1;
            if (i_idx == 2'h0) begin
              next_i_rw = i_shift[0];
              if (i_shift[7:1] != own_addr(sync2[1:0])) begin
                next_i2c_state = I_IDLE;
                next_sda_oe    = 1'b0;
              end
            end else if (i_idx == 2'h1) begin
              next_ptr = i_shift;
            end else begin
              // pointer holds, so every further byte hits the same register
              next_reg_we = 1'b1;
              next_reg_wr = '{addr: ptr, data: i_shift};
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            next_i_bit  = 4'h0;
            next_sda_oe = 1'b0;
            if (i_rw) begin
              // no auto-increment: repeated reads return the same byte
              next_i2c_state   = I_TX;
              next_sda_oe      = ~rd_hold[7];
              next_i_shift     = {rd_hold[6:0], 1'b0};
              next_reg_re      = 1'b1;
              next_reg_wr.addr = ptr;
            end else begin
              next_i2c_state = I_RX;
              next_i_idx     = (i_idx == 2'h2) ? i_idx : i_idx + 2'h1;
            end
          end
        end
        I_TX: begin
          if (scl_rise) begin
            next_i_bit = i_bit + 4'h1;
          end else if (scl_fall) begin
            if (i_bit == BITS_PER_BYTE) begin
              next_i2c_state = I_TXACK;
              next_sda_oe    = 1'b0;
            end else begin
              next_sda_oe  = ~i_shift[7];
              next_i_shift = {i_shift[6:0], 1'b0};
            end
          end
        end
        I_TXACK: begin
          if (scl_rise) begin
            next_i2c_state = sda_h ? I_IDLE : I_ACK;
          end
        end
        default: next_i2c_state = I_IDLE;
      endcase
    end
    // during an spi read the port looks one ahead so the next byte is ready
    next_reg_addr = (next_spi_state == S_READ && SPI_LOCKED) ? ptr_inc(next_ptr) : next_ptr;
    next_dout_oe  = SPI_LOCKED && !cs_h;
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      spi_state <= S_IDLE;
      i2c_state <= I_IDLE;
      ptr       <= PTR_RESET;
      i_bit     <= 4'h0;
      i_shift   <= BYTE_ZERO;
      i_idx     <= 2'h0;
      i_rw      <= 1'b0;
      SDA_OE    <= 1'b0;
      SDA_O     <= 1'b0;
      REG_WE    <= 1'b0;
      REG_RE    <= 1'b0;
      REG_WR    <= '{addr: PTR_RESET, data: BYTE_ZERO};
      REG_ADDR  <= PTR_RESET;
      DOUT_OE   <= 1'b0;
    end else if (MCLK_EN) begin
      spi_state <= next_spi_state;
      i2c_state <= next_i2c_state;
      ptr       <= next_ptr;
      i_bit     <= next_i_bit;
      i_shift   <= next_i_shift;
      i_idx     <= next_i_idx;
      i_rw      <= next_i_rw;
      SDA_OE    <= next_sda_oe;
      REG_WE    <= next_reg_we;
      REG_RE    <= next_reg_re;
      REG_WR    <= next_reg_wr;
      REG_ADDR  <= next_reg_addr;
      DOUT_OE   <= next_dout_oe;
    end
  end

  // ------------------------------------------------------------------
  // limit status and alert pin
  // ------------------------------------------------------------------
  logic [NUM_SOURCES-1:0] status;
  logic [NUM_SOURCES-1:0] next_status;
  logic [NUM_SOURCES-1:0] fault_live;
  logic [NUM_SOURCES-1:0] next_fault_live;
  logic [NUM_SOURCES-1:0] clr_mask;
  logic [7:0]             next_rd_hold;
  logic                   next_alert_oe;

  always_comb begin
    clr_mask = '0;
    if (REG_RE && REG_WR.addr == STATUS1_ADDR) begin
      clr_mask[7:0] = 8'hff;
    end
    if (REG_RE && REG_WR.addr == STATUS2_ADDR) begin
      clr_mask[15:8] = 8'hff;
    end
    next_fault_live = CONV_DONE ? LIMIT_FAULT : fault_live;
    // a read only clears sources that are back within limits; set wins
    next_status = (status & ~(clr_mask & ~next_fault_live))
                | (CONV_DONE ? LIMIT_FAULT : '0);
    unique case (REG_ADDR)
      STATUS1_ADDR: next_rd_hold = status[7:0];
      STATUS2_ADDR: next_rd_hold = status[15:8];
      default:      next_rd_hold = REG_RDATA;
    endcase
    // open drain: enable high sinks the pin, polarity picks which state sinks
    next_alert_oe = !ALERT_DISABLE
                  && (ALERT_POLARITY ? (status == '0) : (status != '0));
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      status     <= '0;
      fault_live <= '0;
      rd_hold    <= BYTE_ZERO;
      ALERT_OE   <= 1'b0;
      ALERT_O    <= 1'b0;
    end else if (MCLK_EN) begin
      status     <= next_status;
      fault_live <= next_fault_live;
      rd_hold    <= next_rd_hold;
      ALERT_OE   <= next_alert_oe;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_ptr_byte_done;
    MCLK_EN && !SPI_LOCKED && i2c_state == I_RX && i_idx == 2'h1
      && scl_fall && i_bit == BITS_PER_BYTE;
  endsequence

  a_lock_sticky: assert property (SPI_LOCKED |=> SPI_LOCKED)
    else $error("spi lock dropped");

  a_i2c_ptr_only: assert property (s_ptr_byte_done |=> !REG_WE && ptr == $past(i_shift))
    else $error("pointer byte did not load pointer alone");

  a_i2c_same_reg: assert property (REG_WE && !SPI_LOCKED |-> REG_WR.addr == ptr)
    else $error("i2c write left the pointed register");

  a_spi_wr_inc: assert property (MCLK_EN && SPI_LOCKED && spi_byte && !cs_rise && !cs_fall
    && spi_state == S_WDATA |=> REG_WE && ptr == ptr_inc(REG_WR.addr))
    else $error("spi write pointer did not advance");

  a_spi_rd_ahead: assert property (MCLK_EN && SPI_LOCKED && spi_state == S_READ
    && !cs_rise |=> REG_ADDR == ptr_inc(ptr))
    else $error("spi read lookahead address wrong");

  a_bad_cmd_quiet: assert property (spi_state == S_SKIP |-> !REG_WE && $stable(ptr))
    else $error("ignored frame changed state");

  a_alert_disable: assert property (MCLK_EN && ALERT_DISABLE |=> !ALERT_OE)
    else $error("disabled alert still sinks");

  a_alert_low: assert property (MCLK_EN && !ALERT_DISABLE && !ALERT_POLARITY
    && status != '0 |=> ALERT_OE)
    else $error("active low alert not asserted");

  a_status_set: assert property (MCLK_EN && CONV_DONE |=> (status & $past(LIMIT_FAULT))
    == $past(LIMIT_FAULT))
    else $error("fault source not recorded");

  a_release_cause: assert property (MCLK_EN && $fell(status != '0) |-> $past(REG_RE))
    else $error("alert released without status read");

  a_dout_float: assert property (MCLK_EN && cs_h |=> !DOUT_OE)
    else $error("dout driven while deselected");

endmodule : dual_serial_register_port

// ==== hw/spi_link_shifter.sv ====
`timescale 1ns/1ps
module spi_link_shifter
  import dsrp_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       link_rst,
  input  wire logic       din,
  input  wire logic [7:0] tx_word,
  output logic [7:0]      rx_byte,
  output logic            byte_tgl,
  output logic            dout
);

  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] next_rx_shift;
  logic [7:0] next_rx_byte;
  logic       next_byte_tgl;
  logic [7:0] tx_shift;
  logic [7:0] next_tx_shift;
  logic       next_dout;

  // ------------------------------------------------------------------
  // receive side, rising edge
  // ------------------------------------------------------------------
  // din shifts in msb first; a full byte is parked and flagged by toggle
  always_comb begin
    next_rx_shift = {rx_shift[6:0], din};
    next_bit_cnt  = bit_cnt + 3'h1;
    next_rx_byte  = rx_byte;
    next_byte_tgl = byte_tgl;
    if (bit_cnt == LAST_BIT) begin
      next_rx_byte  = next_rx_shift;
      next_byte_tgl = ~byte_tgl;
    end
  end

  // cs high holds the frame logic cleared, so din counts only after cs fell
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt  <= 3'h0;
      rx_shift <= BYTE_ZERO;
    end else begin
      bit_cnt  <= next_bit_cnt;
      rx_shift <= next_rx_shift;
    end
  end

  // the parked byte and its toggle outlive the frame for the slow side
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      rx_byte  <= BYTE_ZERO;
      byte_tgl <= 1'b0;
    end else if (!cs_n) begin
      rx_byte  <= next_rx_byte;
      byte_tgl <= next_byte_tgl;
    end
  end

  // ------------------------------------------------------------------
  // transmit side, falling edge
  // ------------------------------------------------------------------
  // tx_word is held steady by the slow side around every byte boundary
  always_comb begin
    next_dout     = tx_shift[7];
    next_tx_shift = {tx_shift[6:0], 1'b0};
    if (bit_cnt == 3'h0) begin
      next_dout     = tx_word[7];
      next_tx_shift = {tx_word[6:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      dout     <= 1'b0;
      tx_shift <= BYTE_ZERO;
    end else begin
      dout     <= next_dout;
      tx_shift <= next_tx_shift;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_byte_count_wrap: assert property (
    @(posedge sclk) disable iff (cs_n)
    (bit_cnt == LAST_BIT) |=> (bit_cnt == 3'h0) && (byte_tgl != $past(byte_tgl)))
    else $error("spi byte toggle missed at bit wrap");

endmodule : spi_link_shifter

// ==== verification/host_model.sv ====
`timescale 1ns/1ps
// ---------------------------------
// host master on the i2c and spi pins
// ---------------------------------
module host_model (
  input  wire logic sda,
  input  wire logic dout,
  output logic      scl,
  output logic      sda_h,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  // idle: i2c released, spi deselected, clock parked low
  initial begin
    {scl, sda_h, cs_n, sclk, din} = 5'h1c;
  end
  // slow phases so the pin synchroniser sees every level
  task automatic ibit(input logic b, output logic r);
    sda_h = b;
    #500 scl = 1;
    #250 r = sda;
    #250 scl = 0;
    #250;
  endtask : ibit
  // s high: start, s low: stop; the sda edge that makes the condition comes with scl high
  task automatic icond(input logic s);
    sda_h = s;
    #250 scl = 1;
    #500 sda_h = !s;
    #500 scl = !s;
    #250;
  endtask : icond
  // msb first, ninth bit released: ack in, or nack out on reads
  task automatic ibyte(input logic [7:0] b, output logic [7:0] g, output logic a);
    for (int i = 7; i >= 0; i--) begin
      ibit(b[i], g[i]);
    end
    ibit(1'b1, a);
  endtask : ibyte
  // chip select edge with settle time around it
  task automatic cs(input logic v);
    #300 cs_n = v;
    #500;
  endtask : cs
  // mode 0 byte at 12 ns; gap lets the crossing settle
  task automatic sbyte(input logic [7:0] b, output logic [7:0] g);
    for (int i = 7; i >= 0; i--) begin
      din = b[i];
      #6 sclk = 1;
      g[i] = dout;
      #6 sclk = 0;
    end
    din = !din;
    #700;
  endtask : sbyte
endmodule : host_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
// ---------------------------------
// bench: i2c pointer, spi lock, frames, alert
// ---------------------------------
module testbench;
  import dsrp_pkg::*;
  logic        mclk = 0, reset = 1, conv = 0, pol = 0, dis = 0, en = 1;
  logic [1:0]  add = ADD_PIN_LOW;
  int          n_re = 0;
  logic [15:0] fault = 16'h0000;
  logic        scl, sda_h, sda, cs_n, sclk, din, dline;
  logic        sda_o, sda_oe, dout, dout_oe, we, re, al_o, al_oe, locked;
  logic [7:0]  raddr;
  logic [7:0]  mem [64];
  reg_wr_t     wr;
  reg_wr_t     wq [$];
  int          n_fail = 0, comparisons = 0;
  always #50 mclk = !mclk;
  // open drain data with pull-up; dout pulled up when floating
  assign sda   = sda_h & !sda_oe;
  assign dline = dout_oe ? dout : 1'b1;
  dual_serial_register_port u_dual_serial_register_port (
    .MCLK(mclk), .RESET(reset), .MCLK_EN(en), .SCL(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
    .DOUT(dout), .DOUT_OE(dout_oe), .ADD_LEVEL(add), .REG_ADDR(raddr),
    .REG_RDATA(mem[raddr[5:0]]), .REG_WR(wr), .REG_WE(we), .REG_RE(re),
    .CONV_DONE(conv), .LIMIT_FAULT(fault), .ALERT_POLARITY(pol),
    .ALERT_DISABLE(dis), .ALERT_O(al_o), .ALERT_OE(al_oe), .SPI_LOCKED(locked));
  host_model u_host_model (
    .sda(sda), .dout(dline), .scl(scl), .sda_h(sda_h), .cs_n(cs_n),
    .sclk(sclk), .din(din));
  // register file stand-in; every write is logged
  always @(posedge mclk) begin
    if (we === 1'b1) begin
      mem[wr.addr[5:0]] <= wr.data;
      wq.push_back(wr);
    end
    // read pulses are counted so the clear-on-read hook is seen
    if (re === 1'b1) begin
      n_re++;
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // spi pointer frame, then one read byte
  task automatic rd(input logic [7:0] p, output logic [7:0] g);
    u_host_model.cs(0);
    u_host_model.sbyte(SPI_CMD_WRITE, g);
    u_host_model.sbyte(p, g);
    u_host_model.cs(1);
    u_host_model.cs(0);
    u_host_model.sbyte(SPI_CMD_READ, g);
    u_host_model.sbyte(8'hff, g);
    u_host_model.cs(1);
  endtask : rd
  task automatic t_i2c();
    logic [7:0] g;
    logic       a;
    u_host_model.icond(1);
    u_host_model.ibyte(8'h90, g, a);
    chk("i2c ack", 0, a);
    chk("sda level", 0, sda_o);
    u_host_model.ibyte(8'h10, g, a);
    u_host_model.ibyte(8'ha1, g, a);
    u_host_model.ibyte(8'ha2, g, a);
    u_host_model.icond(0);
    chk("i2c wr", 16'h10a1, wq[0]);
    chk("i2c rewr", 16'h10a2, wq[1]);
    u_host_model.icond(1);
    u_host_model.ibyte(8'h90, g, a);
    u_host_model.ibyte(8'h25, g, a);
    u_host_model.icond(0);
    chk("ptr only", 2, wq.size());
    u_host_model.icond(1);
    u_host_model.ibyte(8'h91, g, a);
    u_host_model.ibyte(8'hff, g, a);
    u_host_model.icond(0);
    chk("i2c rd", mem[6'h25], g);
    // select pin floating: the low address is refused, the float one taken
    @(negedge mclk);
    add = ADD_PIN_FLOAT;
    repeat (4) @(negedge mclk);
    u_host_model.icond(1);
    u_host_model.ibyte(8'h90, g, a);
    u_host_model.icond(0);
    chk("old addr nack", 1, a);
    u_host_model.icond(1);
    u_host_model.ibyte({I2C_ADDR_UPPER, I2C_ADDR_FLOAT, 1'b0}, g, a);
    chk("float addr ack", 0, a);
    u_host_model.ibyte(8'h25, g, a);
    u_host_model.icond(0);
  endtask : t_i2c
  task automatic t_spi();
    logic [7:0] g;
    logic [7:0] h;
    for (int i = 0; i < 3; i++) begin
      chk("unlocked", 0, locked);
      u_host_model.cs(0);
      u_host_model.cs(1);
    end
    chk("locked", 1, locked);
    chk("dout float", 0, dout_oe);
    wq.delete();
    u_host_model.cs(0);
    u_host_model.sbyte(SPI_CMD_WRITE, g);
    u_host_model.sbyte(8'h3e, g);
    for (int i = 0; i < 3; i++) begin
      u_host_model.sbyte(8'(8'hc0 + i), g);
    end
    u_host_model.cs(1);
    chk("spi wr", 16'h3ec0, wq[0]);
    chk("spi inc", 16'h3fc1, wq[1]);
    chk("spi wrap", 16'h00c2, wq[2]);
    // unknown command: pointer must stay at 01h, the second status byte
    u_host_model.cs(0);
    u_host_model.sbyte(8'h55, g);
    u_host_model.sbyte(8'h12, g);
    u_host_model.cs(1);
    chk("bad cmd", 3, wq.size());
    u_host_model.cs(0);
    u_host_model.sbyte(SPI_CMD_READ, g);
    chk("dout drive", 1, dout_oe);
    u_host_model.sbyte(8'hff, g);
    u_host_model.sbyte(8'hff, h);
    u_host_model.cs(1);
    chk("kept ptr", 0, g);
    chk("rd next", mem[2], h);
    // one i2c byte read plus two spi bytes read
    chk("read pulses", 3, n_re);
  endtask : t_spi
  task automatic t_alert();
    logic [7:0] g;
    // enable low: a fault pulse must leave no trace
    @(negedge mclk);
    en    = 0;
    fault = 16'h0008;
    conv  = 1;
    @(negedge mclk);
    conv  = 0;
    @(negedge mclk);
    en    = 1;
    repeat (2) @(negedge mclk);
    chk("frozen", 0, al_oe);
    conv  = 1;
    @(negedge mclk);
    conv  = 0;
    fault = 16'h0000;
    repeat (2) @(negedge mclk);
    chk("alert on", 1, al_oe);
    chk("alert low", 0, al_o);
    rd(STATUS1_ADDR, g);
    chk("status", 8'h08, g);
    chk("alert held", 1, al_oe);
    @(negedge mclk);
    conv = 1;
    @(negedge mclk);
    conv = 0;
    rd(STATUS1_ADDR, g);
    chk("alert off", 0, al_oe);
    @(negedge mclk);
    dis   = 1;
    fault = 16'h0100;
    conv  = 1;
    @(negedge mclk);
    conv  = 0;
    repeat (3) @(negedge mclk);
    chk("alert dis", 0, al_oe);
    // active high: a pending source leaves the pin released
    dis = 0;
    pol = 1;
    repeat (3) @(negedge mclk);
    chk("alert high", 0, al_oe);
    pol = 0;
    repeat (3) @(negedge mclk);
    chk("alert back", 1, al_oe);
  endtask : t_alert
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'(i * 5 + 3);
    end
    repeat (20) @(negedge mclk);
    reset = 0;
    repeat (5) @(negedge mclk);
    t_i2c();
    t_spi();
    t_alert();
    give_verdict();
  end
endmodule : testbench
